// >>> rtl/ras_pkg.sv
// Purpose: constants and carriers for the register access semantics bank
// Assumes: byte-wide registers on a simple synchronous register port
// Notes: offsets are byte indices into a small local map
// Behaviour
// - read-only bits ignore every write
// - write-only bits read back zero
// - reserved bits always read zero
// - read-only fields never show reserved encodings
// - power reset restores values but loads OUT with zero, soft reset loads OUT_RST and keeps debug control
// - clear alias one clears shared bit
// - set alias one sets shared bit
// - both aliases read the same value
// - simultaneous writes let clear win
package ras_pkg;
   localparam int RAS_DW = 8;
   localparam int RAS_AW = 3;
   localparam logic [2:0] RAS_OFS_CTRL = 3'h0;
   localparam logic [2:0] RAS_OFS_STATUS = 3'h1;
   localparam logic [2:0] RAS_OFS_CMD = 3'h2;
   localparam logic [2:0] RAS_OFS_DBGCTRL = 3'h3;
   localparam logic [2:0] RAS_OFS_OUT = 3'h4;
   localparam logic [2:0] RAS_OFS_OUTSET = 3'h5;
   localparam logic [2:0] RAS_OFS_OUTCLR = 3'h6;
   localparam logic [7:0] RAS_CTRL_MASK = 8'h0F;
   localparam logic [7:0] RAS_CTRL_RST = 8'h00;
   localparam logic [7:0] RAS_DBG_MASK = 8'h01;
   localparam logic [7:0] RAS_DBG_RST = 8'h00;
   localparam logic [7:0] RAS_OUT_RST = 8'h00;
   localparam logic [7:0] RAS_CMD_MASK = 8'h03;
   localparam int RAS_MODE_LSB = 4;
   localparam logic [1:0] RAS_MODE_RSVD = 2'h3;
   localparam logic [1:0] RAS_MODE_IDLE = 2'h0;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [2:0] addr;
      logic [7:0] wdata;
   } ras_req_t;
   typedef struct packed {
      logic valid;
      logic [7:0] rdata;
   } ras_rsp_t;
endpackage

// >>> rtl/ras_setclr_bit.sv
// Purpose: one shared bit reached through a set and a clear alias
// Assumes: strobes already qualified by address decode
// Notes: clear takes precedence over set
`timescale 1ns/1ps
module ras_setclr_bit (
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic i_ce,
   input wire logic i_soft_rst,
   input wire logic i_rst_val,
   input wire logic i_wr,
   input wire logic i_wdata,
   input wire logic i_set,
   input wire logic i_clear,
   output logic o_q
);
   logic bit_d;
   assign bit_d = i_soft_rst ? i_rst_val :
                  i_clear ? 1'b0 :
                  i_set ? 1'b1 :
                  i_wr ? i_wdata : o_q;
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_q <= 1'b0;
      end else if (i_ce) begin
         o_q <= bit_d;
      end
   end
endmodule

// >>> rtl/ras_bank.sv
// Purpose: register bank with read-only, write-only, reserved and set/clear bits
// Assumes: requests synchronous to i_ref_clk; one request per cycle
// Notes: read data registered, valid one cycle after the read strobe
`timescale 1ns/1ps
module ras_bank
   import ras_pkg::*;
#(
   parameter logic [7:0] OUT_RST = RAS_OUT_RST
) (
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic i_ce,
   input wire logic i_soft_rst,
   input wire ras_req_t i_req,
   input wire logic i_set_wr,
   input wire logic [7:0] i_set_data,
   input wire logic [3:0] i_hw_status,
   input wire logic [1:0] i_hw_mode,
   output ras_rsp_t o_rsp,
   output logic [7:0] o_ctrl,
   output logic [7:0] o_out,
   output logic o_dbg,
   output logic [1:0] o_cmd_pulse
);
   logic [7:0] ctrl_q, ctrl_d;
   logic [7:0] dbg_q, dbg_d;
   logic [7:0] out_w;
   logic [7:0] status_q, status_d;
   logic [1:0] cmd_q, cmd_d;
   logic [7:0] rdata_d;
   ras_rsp_t rsp_q;
   logic wr_ctrl, wr_dbg, wr_out, wr_set, wr_clear, wr_cmd;
   logic [1:0] mode_safe;
   logic [7:0] set_mask, clear_mask;

   assign wr_ctrl = i_req.wr && (i_req.addr == RAS_OFS_CTRL);
   assign wr_dbg = i_req.wr && (i_req.addr == RAS_OFS_DBGCTRL);
   assign wr_out = i_req.wr && (i_req.addr == RAS_OFS_OUT);
   assign wr_set = i_req.wr && (i_req.addr == RAS_OFS_OUTSET);
   assign wr_clear = i_req.wr && (i_req.addr == RAS_OFS_OUTCLR);
   assign wr_cmd = i_req.wr && (i_req.addr == RAS_OFS_CMD);

   assign ctrl_d = i_soft_rst ? RAS_CTRL_RST :
                   wr_ctrl ? (i_req.wdata & RAS_CTRL_MASK) : ctrl_q;
   assign dbg_d = (wr_dbg && !i_soft_rst) ? (i_req.wdata & RAS_DBG_MASK) : dbg_q;
   assign mode_safe = (i_hw_mode == RAS_MODE_RSVD) ? RAS_MODE_IDLE : i_hw_mode;
   assign status_d = i_soft_rst ? 8'h00 : {2'h0, mode_safe, i_hw_status};
   assign cmd_d = (wr_cmd && !i_soft_rst) ? i_req.wdata[1:0] : 2'h0;

   assign set_mask = (wr_set ? i_req.wdata : 8'h00) | (i_set_wr ? i_set_data : 8'h00);
   assign clear_mask = wr_clear ? i_req.wdata : 8'h00;

   genvar g;
   generate
      for (g = 0; g < RAS_DW; g++) begin : g_out
         ras_setclr_bit u_bit (
            .i_ref_clk(i_ref_clk),
            .i_resetn(i_resetn),
            .i_ce(i_ce),
            .i_soft_rst(i_soft_rst),
            .i_rst_val(OUT_RST[g]),
            .i_wr(wr_out),
            .i_wdata(i_req.wdata[g]),
            .i_set(set_mask[g]),
            .i_clear(clear_mask[g]),
            .o_q(out_w[g])
         );
      end
   endgenerate

   always_comb begin
      case (i_req.addr)
         RAS_OFS_CTRL: rdata_d = ctrl_q;
         RAS_OFS_STATUS: rdata_d = status_q;
         RAS_OFS_DBGCTRL: rdata_d = dbg_q;
         RAS_OFS_OUT, RAS_OFS_OUTSET, RAS_OFS_OUTCLR: rdata_d = out_w;
         default: rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ctrl_q <= RAS_CTRL_RST;
         dbg_q <= RAS_DBG_RST;
         status_q <= 8'h00;
         cmd_q <= 2'h0;
         rsp_q <= '0;
      end else if (i_ce) begin
         ctrl_q <= ctrl_d;
         dbg_q <= dbg_d;
         status_q <= status_d;
         cmd_q <= cmd_d;
         rsp_q.valid <= i_req.rd;
         rsp_q.rdata <= i_req.rd ? rdata_d : 8'h00;
      end
   end

   assign o_rsp = rsp_q;
   assign o_ctrl = ctrl_q;
   assign o_out = out_w;
   assign o_dbg = dbg_q[0];
   assign o_cmd_pulse = cmd_q;

   property p_ro_ignore;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_ce && i_req.wr && i_req.addr == RAS_OFS_STATUS && !i_soft_rst) |=>
         (status_q == {2'h0, $past(mode_safe), $past(i_hw_status)});
   endproperty
   a_ro_ignore: assert property (p_ro_ignore) else $error("status took a write");

   property p_rsvd_zero;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      rsp_q.valid && $past(i_req.addr) == RAS_OFS_CTRL |-> (rsp_q.rdata & ~RAS_CTRL_MASK) == 8'h00;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit read nonzero");

   property p_mode_legal;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      status_q[RAS_MODE_LSB +: 2] != RAS_MODE_RSVD;
   endproperty
   a_mode_legal: assert property (p_mode_legal) else $error("reserved mode shown");

   property p_soft_rst;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_ce && i_soft_rst) |=> (ctrl_q == RAS_CTRL_RST && out_w == OUT_RST && $stable(dbg_q));
   endproperty
   a_soft_rst: assert property (p_soft_rst) else $error("soft reset values wrong");

   sequence s_clear_wr;
      i_ce && !i_soft_rst && wr_clear;
   endsequence
   property p_clear;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      s_clear_wr |=> ((out_w & $past(i_req.wdata)) == 8'h00);
   endproperty
   a_clear: assert property (p_clear) else $error("clear alias failed");

   sequence s_set_wr;
      i_ce && !i_soft_rst && wr_set;
   endsequence
   property p_set;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      s_set_wr |=> ((out_w & $past(i_req.wdata)) == $past(i_req.wdata));
   endproperty
   a_set: assert property (p_set) else $error("set alias failed");

   property p_alias_same;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_ce && i_req.rd && (i_req.addr == RAS_OFS_OUTSET || i_req.addr == RAS_OFS_OUTCLR))
         |=> rsp_q.valid && rsp_q.rdata == $past(out_w);
   endproperty
   a_alias_same: assert property (p_alias_same) else $error("alias read differs");

   property p_clear_wins;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      (s_clear_wr ##0 (i_set_wr && (i_set_data & i_req.wdata) != 8'h00))
         |=> ((out_w & $past(i_req.wdata)) == 8'h00);
   endproperty
   a_clear_wins: assert property (p_clear_wins) else $error("set beat clear");

   property p_zero_noop;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_ce && !i_soft_rst && wr_set && !i_set_wr) |=>
         ((out_w & ~$past(i_req.wdata)) == ($past(out_w) & ~$past(i_req.wdata)));
   endproperty
   a_zero_noop: assert property (p_zero_noop) else $error("zero bit changed state");

   property p_noop_clear;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      (s_clear_wr ##0 !i_set_wr) |=>
         ((out_w & ~$past(i_req.wdata)) == ($past(out_w) & ~$past(i_req.wdata)));
   endproperty
   a_noop_clear: assert property (p_noop_clear) else $error("clear zero bit acted");

   sequence s_cmd_wr;
      i_ce && !i_soft_rst && wr_cmd;
   endsequence
   property p_cmd_pulse;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      s_cmd_wr |=> (cmd_q == $past(i_req.wdata[1:0]));
   endproperty
   a_cmd_pulse: assert property (p_cmd_pulse) else $error("command not taken");

   property p_cmd_drop;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_ce && !wr_cmd) |=> (cmd_q == 2'h0);
   endproperty
   a_cmd_drop: assert property (p_cmd_drop) else $error("command pulse stuck");

   property p_unmapped_zero;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_ce && i_req.rd && i_req.addr == 3'h7) |=> rsp_q.valid && rsp_q.rdata == 8'h00;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("hole read nonzero");

   property p_dbg_rsvd;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      (dbg_q & ~RAS_DBG_MASK) == 8'h00;
   endproperty
   a_dbg_rsvd: assert property (p_dbg_rsvd) else $error("debug reserved bit set");

   property p_ctrl_rsvd;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      (ctrl_q & ~RAS_CTRL_MASK) == 8'h00;
   endproperty
   a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("control reserved bit set");

   property p_status_follow;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_ce && !i_soft_rst) |=> (status_q[3:0] == $past(i_hw_status));
   endproperty
   a_status_follow: assert property (p_status_follow) else $error("status not shown");

   property p_soft_clear;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_ce && i_soft_rst) |=> (status_q == 8'h00 && cmd_q == 2'h0);
   endproperty
   a_soft_clear: assert property (p_soft_clear) else $error("soft reset left status");
endmodule

// >>> verif/tb_top.sv
// Purpose: self-checking bench for the register access bank
// Assumes: inputs change on the falling edge of i_ref_clk
// Notes: one task per scenario, each judges its own results
`timescale 1ns/1ps
module tb_top;
   import ras_pkg::*;
   logic i_ref_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic i_ce = 1'b1;
   logic i_soft_rst = 1'b0;
   ras_req_t i_req = '0;
   logic i_set_wr = 1'b0;
   logic [7:0] i_set_data = 8'h00;
   logic [3:0] i_hw_status = 4'h0;
   logic [1:0] i_hw_mode = 2'h0;
   ras_rsp_t o_rsp;
   logic [7:0] o_ctrl;
   logic [7:0] o_out;
   logic o_dbg;
   logic [1:0] o_cmd_pulse;
   int failures = 0;
   int cmp_count = 0;

   ras_bank u_ras_bank (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_ce(i_ce),
      .i_soft_rst(i_soft_rst), .i_req(i_req), .i_set_wr(i_set_wr), .i_set_data(i_set_data),
      .i_hw_status(i_hw_status), .i_hw_mode(i_hw_mode), .o_rsp(o_rsp), .o_ctrl(o_ctrl),
      .o_out(o_out), .o_dbg(o_dbg), .o_cmd_pulse(o_cmd_pulse));

   initial begin
      forever #2.5 i_ref_clk = ~i_ref_clk;
   end

   task automatic close_out();
      $display("compares %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // request held until the next falling edge, so one sampling edge
   task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
      i_req.wr = w;
      i_req.rd = !w;
      i_req.addr = a;
      i_req.wdata = d;
      @(negedge i_ref_clk);
   endtask

   task automatic idle();
      i_req = '0;
      @(negedge i_ref_clk);
   endtask

   task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
      acc(1'b0, a, 8'h00);
      chk({7'h00, o_rsp.valid}, 8'h01);
      chk(o_rsp.rdata, exp);
   endtask

   task automatic t_reset();
      chk(o_ctrl, RAS_CTRL_RST);
      chk(o_out, 8'h00);
      chk({7'h00, o_dbg}, RAS_DBG_RST);
      rd_chk(RAS_OFS_CTRL, RAS_CTRL_RST);
      idle();
      $display("test reset values done");
   endtask

   task automatic t_ro();
      i_hw_status = 4'hA;
      i_hw_mode = 2'h2;
      acc(1'b1, RAS_OFS_CTRL, 8'hFF);
      chk(o_ctrl, 8'h0F);
      rd_chk(RAS_OFS_CTRL, 8'h0F);
      acc(1'b1, RAS_OFS_STATUS, 8'hFF);
      rd_chk(RAS_OFS_STATUS, 8'h2A);
      i_hw_mode = RAS_MODE_RSVD;
      i_hw_status = 4'h5;
      idle();
      idle();
      rd_chk(RAS_OFS_STATUS, 8'h05);
      acc(1'b1, RAS_OFS_DBGCTRL, 8'hFF);
      rd_chk(RAS_OFS_DBGCTRL, 8'h01);
      rd_chk(3'h7, 8'h00);
      idle();
      $display("test read-only and reserved done");
   endtask

   task automatic t_cmd();
      acc(1'b1, RAS_OFS_CMD, 8'h03);
      chk({6'h00, o_cmd_pulse}, 8'h03);
      idle();
      chk({6'h00, o_cmd_pulse}, 8'h00);
      $display("test write-only done");
   endtask

   task automatic t_setclr();
      acc(1'b1, RAS_OFS_OUT, 8'h0F);
      acc(1'b1, RAS_OFS_OUTSET, 8'h30);
      chk(o_out, 8'h3F);
      acc(1'b1, RAS_OFS_OUTCLR, 8'h03);
      chk(o_out, 8'h3C);
      rd_chk(RAS_OFS_OUT, 8'h3C);
      rd_chk(RAS_OFS_OUTSET, 8'h3C);
      rd_chk(RAS_OFS_OUTCLR, 8'h3C);
      i_set_wr = 1'b1;
      i_set_data = 8'hC1;
      acc(1'b1, RAS_OFS_OUTCLR, 8'h81);
      i_set_wr = 1'b0;
      chk(o_out, 8'h7C);
      idle();
      $display("test set and clear done");
   endtask

   task automatic t_soft();
      acc(1'b1, RAS_OFS_CTRL, 8'h05);
      acc(1'b1, RAS_OFS_DBGCTRL, 8'h01);
      acc(1'b1, RAS_OFS_OUT, 8'hFF);
      i_ce = 1'b0;
      acc(1'b1, RAS_OFS_CTRL, 8'h0A);
      chk(o_ctrl, 8'h05);
      i_ce = 1'b1;
      i_soft_rst = 1'b1;
      acc(1'b1, RAS_OFS_CTRL, 8'h0A);
      i_soft_rst = 1'b0;
      idle();
      chk(o_ctrl, RAS_CTRL_RST);
      chk(o_out, RAS_OUT_RST);
      chk({7'h00, o_dbg}, 8'h01);
      rd_chk(RAS_OFS_CTRL, RAS_CTRL_RST);
      idle();
      $display("test soft reset done");
   endtask

   task automatic t_por();
      acc(1'b1, RAS_OFS_CTRL, 8'h03);
      acc(1'b1, RAS_OFS_OUTSET, 8'h81);
      idle();
      i_resetn = 1'b0;
      repeat (2) @(negedge i_ref_clk);
      i_resetn = 1'b1;
      chk(o_ctrl, RAS_CTRL_RST);
      chk(o_out, 8'h00);
      chk({7'h00, o_dbg}, RAS_DBG_RST);
      rd_chk(RAS_OFS_OUT, 8'h00);
      idle();
      $display("test power reset done");
   endtask

   initial begin
      repeat (12) @(negedge i_ref_clk);
      i_resetn = 1'b1;
      t_reset();
      t_ro();
      t_cmd();
      t_setclr();
      t_soft();
      t_por();
      close_out();
   end

   // hang guard, tests need well under a microsecond
   initial begin
      #20000;
      failures++;
      close_out();
   end
endmodule
